// [rtl/oled_host_bus_port.sv]
`timescale 1ns/100ps
`include "oled_port_regs.svh"

// Operation
// R1 - With internal oscillator on, drive display clock out on the clock pad.
// R2 - Oscillator select low: oscillator off, display timing from pad input.
// R3 - Chip select active low; transfers ignored while it is high.
// R4 - Hardware reset returns every internal setting to its initial state.
// R5 - Data/command select high marks display data, low marks a command.
// R6 - 8080 mode: data captured at rising edge of active-low write strobe.
// R7 - 6800 mode: write-strobe pin is direction, high read, low write.
// R8 - 6800 mode: read-strobe pin is enable; act while high with select low.
// R9 - 8080 mode: data bus driven only while read strobe is low.
// R10 - Serial mode: pin 0 serial clock, pin 1 data, pins 2-7 undriven.
// R11 - Straps choose bus: 1/1 8080, 0/1 6800, 0/0 serial.
// R12 - Serial: shift data in on rising serial clock, MSB first.
// R13 - Serial: sample data/command and deliver byte on every eighth clock.
// R14 - Host does one dummy read before first display data read.
// R15 - Serial: while deselected, shifter and bit counter held cleared.

module oled_host_bus_port (
   // System
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Mode straps
   input  wire logic       bus_style_select,
   input  wire logic       parallel_select,
   input  wire logic       oscillator_source_select,
   // Host bus pins
   input  wire logic       hardware_reset_in_n,
   input  wire logic       chip_select_n,
   input  wire logic       data_command_select,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic [7:0] data_pin_in,
   output logic      [7:0] data_pin_out,
   output logic      [7:0] data_pin_oe,
   // Display clock pad
   input  wire logic       display_clock_pad_in,
   output logic            display_clock_pad_out,
   output logic            display_clock_pad_oe,
   // Core side
   output logic            display_clock,
   output logic            settings_reset,
   output logic            wr_valid,
   output logic      [7:0] wr_byte,
   output logic            wr_is_data,
   output logic            rd_req,
   output logic            rd_is_data,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_data_valid,
   input  wire logic [7:0] status_byte
);

   serial_link_if lnk ();

   // ---------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------
   localparam int SW = 17;
   logic [SW-1:0] pins_raw;
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic [SW-1:0] sync3_reg;
   logic          tog1_reg;
   logic          tog2_reg;
   logic          tog3_reg;

   assign pins_raw = {display_clock_pad_in, data_pin_in,
                      bus_style_select, parallel_select,
                      oscillator_source_select, hardware_reset_in_n,
                      chip_select_n, data_command_select,
                      write_strobe_n, read_strobe_n};

   always_ff @(posedge mclk) begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      tog1_reg  <= lnk.byte_toggle;
      tog2_reg  <= tog1_reg;
      tog3_reg  <= tog2_reg;
   end

   logic       pad_s;
   logic [7:0] d_s;
   logic       style_s;
   logic       par_s;
   logic       osc_sel_s;
   logic       hw_rst_n_s;
   logic       cs_n_s;
   logic       a0_s;
   logic       wr_n_s;
   logic       rd_n_s;
   logic       wr_n_p;
   logic       rd_n_p;

   assign {pad_s, d_s, style_s, par_s, osc_sel_s, hw_rst_n_s,
           cs_n_s, a0_s, wr_n_s, rd_n_s} = sync2_reg;
   assign wr_n_p = sync3_reg[1];
   assign rd_n_p = sync3_reg[0];

   // ---------------------------------------------------------
   // Serial link wiring
   // ---------------------------------------------------------
   logic link_rst_reg;

   assign lnk.sclk     = data_pin_in[`SER_CLK_PIN];  // [R10]
   assign lnk.sdi      = data_pin_in[`SER_DATA_PIN];  // [R10]
   assign lnk.a0       = data_command_select;
   assign lnk.cs_n     = chip_select_n;
   assign lnk.link_rst = link_rst_reg;

   serial_shift_in u_serial (
      .lnk (lnk.link)
   );

   // ---------------------------------------------------------
   // Control state
   // ---------------------------------------------------------
   logic                      rst_all;
   oled_port_pkg::bus_mode_t  mode_reg;
   oled_port_pkg::bus_mode_t  mode_next;
   logic [`DISP_OSC_CNT_W-1:0] osc_cnt_reg;
   logic [`DISP_OSC_CNT_W-1:0] osc_cnt_next;
   logic                      osc_reg;
   logic                      osc_next;
   logic                      osc_en_reg;
   logic                      osc_en_next;
   logic                      dclk_reg;
   logic                      dclk_next;
   logic [7:0]                latch_reg;
   logic [7:0]                latch_next;
   logic                      wr_valid_reg;
   logic                      wr_valid_next;
   logic [7:0]                wr_byte_reg;
   logic [7:0]                wr_byte_next;
   logic                      wr_is_data_reg;
   logic                      wr_is_data_next;
   logic                      rd_req_reg;
   logic                      rd_req_next;
   logic                      rd_is_data_reg;
   logic                      rd_is_data_next;
   logic [7:0]                pipe_reg;
   logic [7:0]                pipe_next;
   logic [7:0]                dout_reg;
   logic [7:0]                dout_next;
   logic                      oe_reg;
   logic                      oe_next;
   logic                      link_rst_next;

   assign rst_all = ~resetn | ~hw_rst_n_s;  // [R4]

   always_comb begin
      mode_next       = mode_reg;
      osc_en_next     = osc_sel_s;  // [R2]
      osc_cnt_next    = osc_cnt_reg + 9'h001;
      osc_next        = osc_reg;
      dclk_next       = dclk_reg;
      latch_next      = latch_reg;
      wr_valid_next   = 1'b0;
      wr_byte_next    = wr_byte_reg;
      wr_is_data_next = wr_is_data_reg;
      rd_req_next     = 1'b0;
      rd_is_data_next = rd_is_data_reg;
      pipe_next       = pipe_reg;
      dout_next       = dout_reg;
      oe_next         = 1'b0;

      // Strap decode; the undefined 1/0 strap falls back to serial
      if (par_s && style_s) begin
         mode_next = oled_port_pkg::MODE_8080;  // [R11]
      end else if (par_s) begin
         mode_next = oled_port_pkg::MODE_6800;  // [R11]
      end else begin
         mode_next = oled_port_pkg::MODE_SERIAL;  // [R11]
      end

      // Internal oscillator or external pad clock
      if (osc_en_reg) begin
         if (osc_cnt_reg == 9'(`DISP_OSC_HALF_CYC - 1)) begin
            osc_cnt_next = '0;
            osc_next     = ~osc_reg;
         end
         dclk_next = osc_reg;  // [R1]
      end else begin
         osc_cnt_next = '0;
         osc_next     = 1'b0;
         dclk_next    = pad_s;  // [R2]
      end

      if (rd_data_valid) begin
         pipe_next = rd_data;  // [R14]
      end

      case (mode_reg)
         oled_port_pkg::MODE_8080: begin
            if (!wr_n_s) begin
               latch_next = d_s;
            end
            // Write taken on the rising strobe edge
            if (!cs_n_s && wr_n_s && !wr_n_p) begin  // [R3]
               wr_valid_next   = 1'b1;  // [R6]
               wr_byte_next    = latch_reg;  // [R6]
               wr_is_data_next = a0_s;  // [R5]
            end
            if (!cs_n_s && !rd_n_s) begin
               oe_next = 1'b1;  // [R9]
               if (rd_n_p) begin
                  rd_req_next     = a0_s;
                  rd_is_data_next = a0_s;
                  dout_next       = a0_s ? pipe_reg : status_byte;  // [R14]
               end
            end
         end
         oled_port_pkg::MODE_6800: begin
            // Enable high latches, its falling edge commits a write
            if (rd_n_s && !wr_n_s) begin
               latch_next = d_s;  // [R8]
            end
            if (!cs_n_s && !wr_n_s && !rd_n_s && rd_n_p) begin  // [R3]
               wr_valid_next   = 1'b1;  // [R7]
               wr_byte_next    = latch_reg;  // [R8]
               wr_is_data_next = a0_s;  // [R5]
            end
            if (!cs_n_s && wr_n_s && rd_n_s) begin
               oe_next = 1'b1;  // [R7]
               if (!rd_n_p) begin
                  rd_req_next     = a0_s;  // [R8]
                  rd_is_data_next = a0_s;
                  dout_next       = a0_s ? pipe_reg : status_byte;  // [R14]
               end
            end
         end
         default: begin
            // Serial: a new byte shows as a change of the toggle
            if (tog2_reg != tog3_reg) begin
               wr_valid_next   = 1'b1;  // [R13]
               wr_byte_next    = lnk.byte_data;
               wr_is_data_next = lnk.byte_is_data;  // [R5]
            end
         end
      endcase

      link_rst_next = rst_all || (mode_reg != oled_port_pkg::MODE_SERIAL);
   end

   always_ff @(posedge mclk) begin
      if (rst_all) begin  // [R4]
         mode_reg       <= oled_port_pkg::MODE_SERIAL;
         osc_en_reg     <= 1'b0;
         osc_cnt_reg    <= '0;
         osc_reg        <= 1'b0;
         dclk_reg       <= 1'b0;
         latch_reg      <= `BYTE_RESET;
         wr_valid_reg   <= 1'b0;
         wr_byte_reg    <= `BYTE_RESET;
         wr_is_data_reg <= 1'b0;
         rd_req_reg     <= 1'b0;
         rd_is_data_reg <= 1'b0;
         pipe_reg       <= `BYTE_RESET;
         dout_reg       <= `BYTE_RESET;
         oe_reg         <= 1'b0;
         link_rst_reg   <= 1'b1;
      end else begin
         mode_reg       <= mode_next;
         osc_en_reg     <= osc_en_next;
         osc_cnt_reg    <= osc_cnt_next;
         osc_reg        <= osc_next;
         dclk_reg       <= dclk_next;
         latch_reg      <= latch_next;
         wr_valid_reg   <= wr_valid_next;
         wr_byte_reg    <= wr_byte_next;
         wr_is_data_reg <= wr_is_data_next;
         rd_req_reg     <= rd_req_next;
         rd_is_data_reg <= rd_is_data_next;
         pipe_reg       <= pipe_next;
         dout_reg       <= dout_next;
         oe_reg         <= oe_next;
         link_rst_reg   <= link_rst_next;
      end
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   logic settings_reset_reg;

   always_ff @(posedge mclk) begin
      settings_reset_reg <= rst_all;
   end

   assign data_pin_out          = dout_reg;
   assign data_pin_oe           = {8{oe_reg}};  // [R10]
   assign display_clock_pad_out = osc_reg;  // [R1]
   assign display_clock_pad_oe  = osc_en_reg;  // [R1]
   assign display_clock         = dclk_reg;
   assign settings_reset        = settings_reset_reg;
   assign wr_valid              = wr_valid_reg;
   assign wr_byte               = wr_byte_reg;
   assign wr_is_data            = wr_is_data_reg;
   assign rd_req                = rd_req_reg;
   assign rd_is_data            = rd_is_data_reg;

endmodule

// [rtl/oled_port_regs.svh]
`ifndef OLED_PORT_REGS_SVH
`define OLED_PORT_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS      8
`define DISP_OSC_HALF_NS    2000
`define DISP_OSC_HALF_CYC   (`DISP_OSC_HALF_NS / `MCLK_PERIOD_NS)
`define DISP_OSC_CNT_W      9

// ----------------------------------------------------------------
// Bus and reset values
// ----------------------------------------------------------------
`define BUS_W               8
`define SER_CNT_W           3
`define SER_LAST_BIT        3'h7
`define BYTE_RESET          8'h00
`define SER_CLK_PIN         0
`define SER_DATA_PIN        1

`endif

// [rtl/oled_port_pkg.sv]
package oled_port_pkg;

   typedef enum logic [1:0] {
      MODE_8080,
      MODE_6800,
      MODE_SERIAL
   } bus_mode_t;

endpackage

// [rtl/serial_link_if.sv]
`timescale 1ns/100ps

interface serial_link_if;
   logic       sclk;
   logic       sdi;
   logic       a0;
   logic       cs_n;
   logic       link_rst;
   logic       byte_toggle;
   logic [7:0] byte_data;
   logic       byte_is_data;

   modport link (
      input  sclk, sdi, a0, cs_n, link_rst,
      output byte_toggle, byte_data, byte_is_data
   );

   modport core (
      output sclk, sdi, a0, cs_n, link_rst,
      input  byte_toggle, byte_data, byte_is_data
   );
endinterface

// [rtl/serial_shift_in.sv]
`timescale 1ns/100ps
`include "oled_port_regs.svh"

module serial_shift_in (
   // Link to the core
   serial_link_if.link lnk
);

   logic                  clear;
   logic [7:0]            shift_reg;
   logic [7:0]            shift_next;
   logic [`SER_CNT_W-1:0] count_reg;
   logic [`SER_CNT_W-1:0] count_next;
   logic [7:0]            byte_reg;
   logic [7:0]            byte_next;
   logic                  is_data_reg;
   logic                  is_data_next;
   logic                  toggle_reg;
   logic                  toggle_next;

   // Deselect holds the shifter at bit zero
   assign clear = lnk.cs_n | lnk.link_rst;  // [R15]

   // ---------------------------------------------------------
   // Shift and byte capture
   // ---------------------------------------------------------
   always_comb begin
      shift_next   = {shift_reg[6:0], lnk.sdi};  // [R12]
      count_next   = count_reg + 3'h1;
      byte_next    = byte_reg;
      is_data_next = is_data_reg;
      toggle_next  = toggle_reg;
      if (count_reg == `SER_LAST_BIT) begin
         byte_next    = {shift_reg[6:0], lnk.sdi};  // [R13]
         is_data_next = lnk.a0;  // [R13]
         toggle_next  = ~toggle_reg;
      end
   end

   always_ff @(posedge lnk.sclk or posedge clear) begin
      if (clear) begin
         shift_reg <= `BYTE_RESET;  // [R15]
         count_reg <= '0;
      end else begin
         shift_reg <= shift_next;
         count_reg <= count_next;
      end
   end

   always_ff @(posedge lnk.sclk or posedge lnk.link_rst) begin
      if (lnk.link_rst) begin
         byte_reg    <= `BYTE_RESET;
         is_data_reg <= 1'b0;
         toggle_reg  <= 1'b0;
      end else begin
         byte_reg    <= byte_next;
         is_data_reg <= is_data_next;
         toggle_reg  <= toggle_next;
      end
   end

   assign lnk.byte_toggle  = toggle_reg;
   assign lnk.byte_data    = byte_reg;
   assign lnk.byte_is_data = is_data_reg;

endmodule

// [testbench/oled_port_assertions.sv]
`timescale 1ns/100ps

module oled_port_checker (
   // Clock and pins
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic       bus_style_select,
   input wire logic       parallel_select,
   input wire logic       oscillator_source_select,
   input wire logic       hardware_reset_in_n,
   input wire logic       chip_select_n,
   input wire logic       read_strobe_n,
   input wire logic       display_clock_pad_in,
   // Watched outputs
   input wire logic [7:0] data_pin_oe,
   input wire logic       display_clock_pad_oe,
   input wire logic       display_clock,
   input wire logic       settings_reset,
   input wire logic       wr_valid,
   input wire logic       rd_req,
   input wire logic       rd_is_data
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence rd_on_s;
      (parallel_select && bus_style_select && !chip_select_n
         && !read_strobe_n)[*6];
   endsequence
   sequence rd_off_s;
      (parallel_select && bus_style_select && read_strobe_n)[*6];
   endsequence

   serial_hiz_a: assert property (
      (!parallel_select && !bus_style_select)[*6] |-> data_pin_oe == 8'h00)
      else $error("data bus driven in serial mode");
   rd_drive_a: assert property (rd_on_s |-> data_pin_oe == 8'hff)
      else $error("data bus not driven during read");
   rd_release_a: assert property (rd_off_s |-> data_pin_oe == 8'h00)
      else $error("data bus driven outside read");
   cs_gate_a: assert property (chip_select_n[*8] |-> !wr_valid)
      else $error("write accepted while deselected");
   wr_pulse_a: assert property (wr_valid |=> !wr_valid)
      else $error("write pulse longer than one cycle");
   rd_kind_a: assert property (rd_req |-> rd_is_data ##1 !rd_req)
      else $error("read request not a data read");
   pin_reset_a: assert property (
      !hardware_reset_in_n[*4] |-> settings_reset)
      else $error("pin reset not applied");
   osc_on_a: assert property (
      oscillator_source_select[*4] |-> display_clock_pad_oe)
      else $error("clock pad not driven with oscillator on");
   osc_off_a: assert property (
      !oscillator_source_select[*4] |-> !display_clock_pad_oe)
      else $error("clock pad driven with oscillator off");
   ext_still_a: assert property (
      (!oscillator_source_select && $stable(display_clock_pad_in))[*6]
      |-> $stable(display_clock))
      else $error("display clock moves without pad clock");
endmodule

bind oled_host_bus_port oled_port_checker oled_port_checker_inst (
   .mclk, .resetn, .bus_style_select, .parallel_select,
   .oscillator_source_select, .hardware_reset_in_n, .chip_select_n,
   .read_strobe_n, .display_clock_pad_in, .data_pin_oe,
   .display_clock_pad_oe, .display_clock, .settings_reset, .wr_valid,
   .rd_req, .rd_is_data);

// [testbench/host_bus_model.sv]
`timescale 1ns/100ps

module host_bus_model (
   // Clock
   input wire logic       mclk,
   // Host pins
   output logic           cs_n,
   output logic           dc,
   output logic           wr_n,
   output logic           rd_n,
   output logic     [7:0] dq,
   input wire logic [7:0] dq_in
);
   initial begin
      cs_n = 1'b1;
      dc   = 1'b0;
      wr_n = 1'b1;
      rd_n = 1'b1;
      dq   = 8'h00;
   end

   // ------------------------------------------------
   // Parallel cycle, 8080 or 6800 style
   // ------------------------------------------------
   task automatic xfer(input logic m68, rd, a0, sel,
                       input logic [7:0] d, output logic [7:0] q);
      // Direction and enable settle while still deselected
      @(negedge mclk);
      dc   = a0;
      dq   = d;
      wr_n = m68 ? rd : 1'b1;
      rd_n = !m68;
      repeat (4) @(negedge mclk);
      cs_n = !sel;
      if (m68)
         rd_n = 1'b1;
      else if (rd)
         rd_n = 1'b0;
      else
         wr_n = 1'b0;
      repeat (8) @(negedge mclk);
      q    = dq_in;
      rd_n = !m68;
      wr_n = m68 ? rd : 1'b1;
      repeat (6) @(negedge mclk);
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      dq   = ~d;
   endtask

   // Serial frame; clock stands low outside frames
   task automatic ser(input logic a0, input logic [7:0] d, input int n);
      @(negedge mclk);
      dq[0] = 1'b0;
      #3 cs_n = 1'b0;
      dc = a0;
      for (int i = 7; i > 7 - n; i--) begin
         dq[1] = d[i];
         #24 dq[0] = 1'b1;
         #24 dq[0] = 1'b0;
      end
      #24 cs_n = 1'b1;
      dq[1] = ~dq[1];
   endtask
endmodule

// [testbench/oled_host_bus_port_tb_top.sv]
`timescale 1ns/100ps

module oled_host_bus_port_tb_top;
   logic       mclk = 1'b0;
   logic       resetn = 1'b0;
   logic       bus_style_select = 1'b0;
   logic       parallel_select = 1'b0;
   logic       oscillator_source_select = 1'b0;
   logic       hardware_reset_in_n = 1'b1;
   logic       ext_clk = 1'b0;
   logic [7:0] rd_data = 8'h30;
   logic       rd_data_valid = 1'b0;
   logic [7:0] status_byte = 8'h00;
   wire        chip_select_n;
   wire        data_command_select;
   wire        write_strobe_n;
   wire        read_strobe_n;
   wire  [7:0] host_dq;
   wire  [7:0] data_pin_in;
   wire        display_clock_pad_in;
   logic [7:0] data_pin_out;
   logic [7:0] data_pin_oe;
   logic       display_clock_pad_out;
   logic       display_clock_pad_oe;
   logic       display_clock;
   logic       settings_reset;
   logic       wr_valid;
   logic [7:0] wr_byte;
   logic       wr_is_data;
   logic       rd_req;
   logic       rd_is_data;
   int         fail_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   int         wr_cnt = 0;

   always #4 mclk = ~mclk;

   assign data_pin_in = (data_pin_oe & data_pin_out)
      | (~data_pin_oe & host_dq);
   assign display_clock_pad_in = display_clock_pad_oe ? display_clock_pad_out
      : ext_clk;

   oled_host_bus_port oled_host_bus_port_inst (
      .mclk, .resetn, .bus_style_select, .parallel_select,
      .oscillator_source_select, .hardware_reset_in_n, .chip_select_n,
      .data_command_select, .write_strobe_n, .read_strobe_n, .data_pin_in,
      .data_pin_out, .data_pin_oe, .display_clock_pad_in,
      .display_clock_pad_out, .display_clock_pad_oe, .display_clock,
      .settings_reset, .wr_valid, .wr_byte, .wr_is_data, .rd_req,
      .rd_is_data, .rd_data, .rd_data_valid, .status_byte);

   host_bus_model host_bus_model_inst (
      .mclk, .cs_n(chip_select_n), .dc(data_command_select),
      .wr_n(write_strobe_n), .rd_n(read_strobe_n), .dq(host_dq),
      .dq_in(data_pin_in));

   // ------------------------------------------------
   // Core side answers and run limit
   // ------------------------------------------------
   always @(negedge mclk) begin
      rd_data_valid <= 1'b0;
      if (rd_req === 1'b1) begin
         rd_data_valid <= 1'b1;
         rd_data       <= rd_data + 8'h11;
      end
      if (wr_valid === 1'b1)
         wr_cnt <= wr_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic summarize();
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic set_mode(input logic b, p);
      @(negedge mclk);
      bus_style_select = b;
      parallel_select  = p;
      resetn           = 1'b0;
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      repeat (6) @(negedge mclk);
   endtask

   task automatic pwr(input logic [1:0] m, input logic a0, sel,
                      input logic [7:0] d, e);
      int         c;
      logic [7:0] q;
      c = wr_cnt;
      if (m == 2'h2)
         host_bus_model_inst.ser(a0, d, 8);
      else
         host_bus_model_inst.xfer(m[0], 1'b0, a0, sel, d, q);
      repeat (8) @(negedge mclk);
      chk("wr_byte", e, wr_byte);
      chk("wr_count", {7'h0, sel}, 8'(wr_cnt - c));
      if (sel)
         chk("wr_is_data", {7'h0, a0}, {7'h0, wr_is_data});
   endtask

   task automatic prd(input logic m68, a0, input logic [7:0] e);
      logic [7:0] q;
      host_bus_model_inst.xfer(m68, 1'b1, a0, 1'b1, 8'h00, q);
      chk("rd_data", e, q);
   endtask

   initial begin
      logic [7:0] q;
      logic       t;
      int         n;
      repeat (4) @(negedge mclk);
      chk("oe_rst", 8'h00, data_pin_oe);
      chk("set_rst", 8'h01, {7'h0, settings_reset});
      resetn = 1'b1;
      set_mode(1'b1, 1'b1);
      pwr(2'h0, 1'b1, 1'b1, 8'h3c, 8'h3c);
      pwr(2'h0, 1'b0, 1'b1, 8'hc3, 8'hc3);
      pwr(2'h0, 1'b1, 1'b0, 8'hff, 8'hc3);
      status_byte = 8'h96;
      prd(1'b0, 1'b0, 8'h96);
      host_bus_model_inst.xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, q);
      prd(1'b0, 1'b1, 8'h41);
      set_mode(1'b0, 1'b1);
      pwr(2'h1, 1'b1, 1'b1, 8'h5a, 8'h5a);
      status_byte = 8'h69;
      prd(1'b1, 1'b0, 8'h69);
      set_mode(1'b0, 1'b0);
      host_bus_model_inst.ser(1'b1, 8'hff, 4);
      pwr(2'h2, 1'b1, 1'b1, 8'hb2, 8'hb2);
      pwr(2'h2, 1'b0, 1'b1, 8'h4d, 8'h4d);
      hardware_reset_in_n = 1'b0;
      repeat (5) @(negedge mclk);
      chk("pin_rst", 8'h01, {7'h0, settings_reset});
      hardware_reset_in_n = 1'b1;
      repeat (5) @(negedge mclk);
      chk("pin_rst", 8'h00, {7'h0, settings_reset});
      oscillator_source_select = 1'b1;
      repeat (6) @(negedge mclk);
      chk("pad_oe", 8'h01, {7'h0, display_clock_pad_oe});
      t = display_clock_pad_out;
      n = 0;
      while (display_clock_pad_out === t && n < 300) begin
         @(negedge mclk);
         n++;
      end
      chk("pad_toggle", 8'h01, {7'h0, n < 300});
      oscillator_source_select = 1'b0;
      repeat (6) @(negedge mclk);
      chk("pad_oe", 8'h00, {7'h0, display_clock_pad_oe});
      repeat (4) begin
         ext_clk = !ext_clk;
         repeat (8) @(negedge mclk);
         chk("disp_clk", {7'h0, ext_clk}, {7'h0, display_clock});
      end
      summarize();
   end
endmodule
